// ===== logic/lucb_config_bank.sv
/*
 * index/data configuration register bank with per-unit banks.
 * assumes one-cycle port strobes synchronous to clk.
 */
`include "lucb_defs.svh"
module lucb_config_bank #(
   parameter int NUM_UNITS = 9,
   parameter logic [NUM_UNITS-1:0] FIXED_TYPE = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic index_wr,
   input wire logic index_rd,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input wire logic [7:0] glb_rd_data,
   output logic glb_wr,
   output logic glb_rd,
   output logic [7:0] glb_index,
   input wire logic [NUM_UNITS-1:0] unit_irq,
   output logic [7:0] logical_unit_selector,
   output logic memory_space_enable,
   output logic [15:0] memory_base_upper,
   output logic [NUM_UNITS-1:0] unit_active,
   output logic [NUM_UNITS-1:0] unit_in_memory,
   output logic [NUM_UNITS-1:0] unit_irq_wake_status,
   output logic power_event_request,
   output logic [NUM_UNITS*16-1:0] unit_io_base0,
   output logic [NUM_UNITS*16-1:0] unit_io_base1,
   output logic [NUM_UNITS*4-1:0] unit_irq_line,
   output logic [NUM_UNITS*2-1:0] unit_irq_type
);
   // ==========================================================
   // global state
   logic [7:0] idx_reg, idx_next, sel_reg, sel_next, map_reg, map_next;
   logic [7:0] mbm_reg, mbm_next, mbt_reg, mbt_next, rd_reg, rd_next;
   logic [NUM_UNITS-1:0] sts_reg, sts_next, pme_pulse;
   lucb_pkg::lucb_reg_t dec;
   logic sel_valid;
   logic [7:0] u_act [NUM_UNITS];
   logic [7:0] u_spc [NUM_UNITS];
   logic [15:0] u_io0 [NUM_UNITS];
   logic [15:0] u_io1 [NUM_UNITS];
   logic [7:0] u_irq [NUM_UNITS];
   logic [7:0] u_irqt [NUM_UNITS];

   // index decode
   always_comb begin
      unique case (idx_reg)
         `LUCB_IDX_SEL: dec = lucb_pkg::LUCB_R_SEL;
         `LUCB_IDX_MAP: dec = lucb_pkg::LUCB_R_MAP;
         `LUCB_IDX_MBMID: dec = lucb_pkg::LUCB_R_MBMID;
         `LUCB_IDX_MBTOP: dec = lucb_pkg::LUCB_R_MBTOP;
         `LUCB_IDX_ACT: dec = lucb_pkg::LUCB_R_ACT;
         `LUCB_IDX_SPACE: dec = lucb_pkg::LUCB_R_SPACE;
         `LUCB_IDX_IO0H: dec = lucb_pkg::LUCB_R_IO0H;
         `LUCB_IDX_IO0L: dec = lucb_pkg::LUCB_R_IO0L;
         `LUCB_IDX_IO1H: dec = lucb_pkg::LUCB_R_IO1H;
         `LUCB_IDX_IO1L: dec = lucb_pkg::LUCB_R_IO1L;
         `LUCB_IDX_IRQ: dec = lucb_pkg::LUCB_R_IRQ;
         `LUCB_IDX_IRQT: dec = lucb_pkg::LUCB_R_IRQT;
         `LUCB_IDX_DMA0, `LUCB_IDX_DMA1: dec = lucb_pkg::LUCB_R_DMA;
         default: begin
            if (idx_reg >= `LUCB_IDX_GLB_LO && idx_reg <= `LUCB_IDX_GLB_HI) begin
               dec = lucb_pkg::LUCB_R_GLB;
            end else begin
               dec = lucb_pkg::LUCB_R_NONE;
            end
         end
      endcase
   end

   // banked accesses only reach a valid unit number
   assign sel_valid = (sel_reg < 8'(NUM_UNITS));

   // per-unit banks
   genvar g;
   generate
      for (g = 0; g < NUM_UNITS; g = g + 1) begin : gen_unit
         lucb_unit_bank #(
            .FIXED_TYPE(FIXED_TYPE[g]),
            .FIXED_IRQT(2'b01)
         ) u_bank (
            .clk(clk),
            .rst_n(rst_n),
            .wr_en(data_wr && sel_valid && (sel_reg == 8'(g))),
            .wr_reg(dec),
            .wr_data(wr_data),
            .unit_irq(unit_irq[g]),
            .memory_space_enable(memory_space_enable),
            .activation(u_act[g]),
            .space_sel(u_spc[g]),
            .io_base0(u_io0[g]),
            .io_base1(u_io1[g]),
            .irq_sel(u_irq[g]),
            .irq_type(u_irqt[g]),
            .unit_active(unit_active[g]),
            .unit_in_memory(unit_in_memory[g]),
            .power_event_request(pme_pulse[g])
         );
         assign unit_io_base0[g*16 +: 16] = u_io0[g];
         assign unit_io_base1[g*16 +: 16] = u_io1[g];
         assign unit_irq_line[g*4 +: 4] = u_irq[g][3:0];
         assign unit_irq_type[g*2 +: 2] = u_irqt[g][1:0];
      end
   endgenerate

   // next values of global registers and read data
   always_comb begin
      idx_next = index_wr ? wr_data : idx_reg;
      sel_next = sel_reg;
      map_next = map_reg;
      mbm_next = mbm_reg;
      mbt_next = mbt_reg;
      // wake status: new event wins over nothing; cleared only by reset
      sts_next = sts_reg | pme_pulse;
      if (data_wr) begin
         unique case (dec)
            lucb_pkg::LUCB_R_SEL: sel_next = wr_data;
            lucb_pkg::LUCB_R_MAP: map_next = wr_data;
            lucb_pkg::LUCB_R_MBMID: mbm_next = wr_data;
            lucb_pkg::LUCB_R_MBTOP: mbt_next = wr_data;
            default: sel_next = sel_reg;
         endcase
      end
      rd_next = rd_reg;
      if (index_rd) begin
         rd_next = idx_reg;
      end else if (data_rd) begin
         rd_next = `LUCB_UNUSED;
         unique case (dec)
            lucb_pkg::LUCB_R_SEL: rd_next = sel_reg;
            lucb_pkg::LUCB_R_MAP: rd_next = map_reg;
            lucb_pkg::LUCB_R_MBMID: rd_next = mbm_reg;
            lucb_pkg::LUCB_R_MBTOP: rd_next = mbt_reg;
            lucb_pkg::LUCB_R_GLB: rd_next = glb_rd_data;
            lucb_pkg::LUCB_R_DMA: rd_next = `LUCB_DMA_NONE;
            lucb_pkg::LUCB_R_NONE: rd_next = `LUCB_UNUSED;
            default: begin
               if (sel_valid) begin
                  unique case (dec)
                     lucb_pkg::LUCB_R_ACT: rd_next = u_act[sel_reg[3:0]];
                     lucb_pkg::LUCB_R_SPACE: rd_next = u_spc[sel_reg[3:0]];
                     lucb_pkg::LUCB_R_IO0H: rd_next = u_io0[sel_reg[3:0]][15:8];
                     lucb_pkg::LUCB_R_IO0L: rd_next = u_io0[sel_reg[3:0]][7:0];
                     lucb_pkg::LUCB_R_IO1H: rd_next = u_io1[sel_reg[3:0]][15:8];
                     lucb_pkg::LUCB_R_IO1L: rd_next = u_io1[sel_reg[3:0]][7:0];
                     lucb_pkg::LUCB_R_IRQ: rd_next = u_irq[sel_reg[3:0]];
                     lucb_pkg::LUCB_R_IRQT: rd_next = u_irqt[sel_reg[3:0]];
                     default: rd_next = `LUCB_UNUSED;
                  endcase
               end
            end
         endcase
      end
   end

   // global registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idx_reg <= 8'h00;
         sel_reg <= 8'h00;
         map_reg <= 8'h00;
         mbm_reg <= 8'h00;
         mbt_reg <= 8'h00;
         sts_reg <= '0;
         rd_reg <= 8'h00;
      end else begin
         idx_reg <= idx_next;
         sel_reg <= sel_next;
         map_reg <= map_next;
         mbm_reg <= mbm_next;
         mbt_reg <= mbt_next;
         sts_reg <= sts_next;
         rd_reg <= rd_next;
      end
   end

   // outputs
   assign rd_data = rd_reg;
   assign glb_wr = data_wr && (dec == lucb_pkg::LUCB_R_GLB);
   assign glb_rd = data_rd && (dec == lucb_pkg::LUCB_R_GLB);
   assign glb_index = idx_reg;
   assign logical_unit_selector = sel_reg;
   assign memory_space_enable = map_reg[`LUCB_MAP_EN_BIT];
   assign memory_base_upper = {mbt_reg, mbm_reg};
   assign unit_irq_wake_status = sts_reg;
   assign power_event_request = |pme_pulse;
endmodule

// ===== logic/lucb_defs.svh
/*
 * constants for the logical unit configuration bank: indices, fields,
 * read values.
 * assumes inclusion by bare name from the modules.
 */
`ifndef LUCB_DEFS_SVH
`define LUCB_DEFS_SVH
// ==========================================================
// Function
// - bank registers read/write except 71h of fixed-type units; undefined bits reserved
// - reserved bits read back as zero; 10h bits 7-1 read back as written
// - index 07h holds selected unit number
// - index 10h enables memory-space register mapping
// - 12h/13h hold memory base bits 23-16, 31-24
// - 20h-2Fh decoded as global device registers
// - 30h bit 0 activates selected unit
// - 50h bit 0 selects memory space, gated
// - 60h/61h hold first I/O base
// - 62h/63h hold second I/O base
// - 70h bits 3-0 select interrupt line
// - 70h bit 4 enables wake event on interrupt
// - 71h bit 1 sets interrupt polarity
// - 71h bit 0 sets edge or level trigger
// - fixed-type units keep type bits read-only
// - indices 30h-71h are banked per unit; DMA indices 74h/75h read the same for every unit
// - unimplemented reads 00h, DMA indices 04h
// - activation enables runtime access; config stays open
// ==========================================================
`define LUCB_IDX_SEL 8'h07
`define LUCB_IDX_MAP 8'h10
`define LUCB_IDX_MBMID 8'h12
`define LUCB_IDX_MBTOP 8'h13
`define LUCB_IDX_GLB_LO 8'h20
`define LUCB_IDX_GLB_HI 8'h2f
`define LUCB_IDX_BANK 8'h30
`define LUCB_IDX_ACT 8'h30
`define LUCB_IDX_SPACE 8'h50
`define LUCB_IDX_IO0H 8'h60
`define LUCB_IDX_IO0L 8'h61
`define LUCB_IDX_IO1H 8'h62
`define LUCB_IDX_IO1L 8'h63
`define LUCB_IDX_IRQ 8'h70
`define LUCB_IDX_IRQT 8'h71
`define LUCB_IDX_DMA0 8'h74
`define LUCB_IDX_DMA1 8'h75
`define LUCB_DMA_NONE 8'h04
`define LUCB_UNUSED 8'h00
`define LUCB_MAP_EN_BIT 0
`define LUCB_WAKE_BIT 4
`define LUCB_POL_BIT 1
`define LUCB_TYPE_BIT 0
`define LUCB_IRQ_MASK 8'h1f
`define LUCB_IRQT_MASK 8'h03
`endif

// ===== logic/lucb_pkg.sv
/*
 * types for the logical unit configuration bank.
 * assumes lucb_defs.svh is on the include path.
 */
package lucb_pkg;
   // which register group an index decodes to
   typedef enum logic [3:0] {
      LUCB_R_NONE, LUCB_R_SEL, LUCB_R_MAP, LUCB_R_MBMID, LUCB_R_MBTOP, LUCB_R_GLB,
      LUCB_R_ACT, LUCB_R_SPACE, LUCB_R_IO0H, LUCB_R_IO0L, LUCB_R_IO1H, LUCB_R_IO1L,
      LUCB_R_IRQ, LUCB_R_IRQT, LUCB_R_DMA
   } lucb_reg_t;
endpackage

// ===== logic/lucb_unit_bank.sv
/*
 * one logical unit's banked configuration registers and wake logic.
 * assumes writes arrive as one-cycle strobes already decoded.
 */
`include "lucb_defs.svh"
module lucb_unit_bank #(
   parameter logic FIXED_TYPE = 1'b0,
   parameter logic [1:0] FIXED_IRQT = 2'b00
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire lucb_pkg::lucb_reg_t wr_reg,
   input wire logic [7:0] wr_data,
   input wire logic unit_irq,
   input wire logic memory_space_enable,
   output logic [7:0] activation,
   output logic [7:0] space_sel,
   output logic [15:0] io_base0,
   output logic [15:0] io_base1,
   output logic [7:0] irq_sel,
   output logic [7:0] irq_type,
   output logic unit_active,
   output logic unit_in_memory,
   output logic power_event_request
);
   // ==========================================================
   // register state
   logic [7:0] act_reg, act_next, spc_reg, spc_next, irq_reg, irq_next, irqt_reg, irqt_next;
   logic [15:0] io0_reg, io0_next, io1_reg, io1_next;
   logic pme_reg, pme_next;

   // next values from strobed writes
   always_comb begin
      act_next = act_reg;
      spc_next = spc_reg;
      io0_next = io0_reg;
      io1_next = io1_reg;
      irq_next = irq_reg;
      irqt_next = irqt_reg;
      if (wr_en) begin
         unique case (wr_reg)
            lucb_pkg::LUCB_R_ACT: act_next = {7'h00, wr_data[0]};
            lucb_pkg::LUCB_R_SPACE: spc_next = {7'h00, wr_data[0]};
            lucb_pkg::LUCB_R_IO0H: io0_next[15:8] = wr_data;
            lucb_pkg::LUCB_R_IO0L: io0_next[7:0] = wr_data;
            lucb_pkg::LUCB_R_IO1H: io1_next[15:8] = wr_data;
            lucb_pkg::LUCB_R_IO1L: io1_next[7:0] = wr_data;
            lucb_pkg::LUCB_R_IRQ: irq_next = wr_data & `LUCB_IRQ_MASK;
            lucb_pkg::LUCB_R_IRQT: irqt_next = FIXED_TYPE ? irqt_reg
                                       : (wr_data & `LUCB_IRQT_MASK);
            default: act_next = act_reg;
         endcase
      end
      // wake event only with enable and an assigned line
      pme_next = unit_irq && irq_reg[`LUCB_WAKE_BIT] && (irq_reg[3:0] != 4'h0);
   end

   // registers; reset clears activation, space select and wake enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         act_reg <= 8'h00;
         spc_reg <= 8'h00;
         io0_reg <= 16'h0000;
         io1_reg <= 16'h0000;
         irq_reg <= 8'h00;
         irqt_reg <= FIXED_TYPE ? {6'h00, FIXED_IRQT} : 8'h00;
         pme_reg <= 1'b0;
      end else begin
         act_reg <= act_next;
         spc_reg <= spc_next;
         io0_reg <= io0_next;
         io1_reg <= io1_next;
         irq_reg <= irq_next;
         irqt_reg <= irqt_next;
         pme_reg <= pme_next;
      end
   end

   // outputs
   assign activation = act_reg;
   assign space_sel = spc_reg;
   assign io_base0 = io0_reg;
   assign io_base1 = io1_reg;
   assign irq_sel = irq_reg;
   assign irq_type = irqt_reg;
   assign unit_active = act_reg[0];
   assign unit_in_memory = spc_reg[0] & memory_space_enable;
   assign power_event_request = pme_reg;
endmodule

// ===== testbench/lucb_config_bank_monitor.sv
/*
 checker for the configuration bank's ports.
 assumes binding to every lucb_config_bank instance, one clock domain.
*/
module lucb_config_bank_monitor #(
   parameter int NUM_UNITS = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic glb_wr,
   input wire logic glb_rd,
   input wire logic [7:0] glb_index,
   input wire logic [NUM_UNITS-1:0] unit_irq,
   input wire logic [7:0] logical_unit_selector,
   input wire logic memory_space_enable,
   input wire logic [15:0] memory_base_upper,
   input wire logic [NUM_UNITS-1:0] unit_in_memory,
   input wire logic [NUM_UNITS-1:0] unit_irq_wake_status,
   input wire logic power_event_request
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // port relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_glb_wr_range: assert property (glb_wr |-> data_wr && glb_index inside {[8'h20:8'h2f]})
      else $error("global write strobe out of range");
   chk_glb_rd_range: assert property (glb_rd |-> data_rd && glb_index inside {[8'h20:8'h2f]})
      else $error("global read strobe out of range");
   chk_glb_wr_hit: assert property (data_wr && glb_index inside {[8'h20:8'h2f]} |-> glb_wr)
      else $error("global write strobe missing");
   chk_sel_write: assert property (data_wr && glb_index == 8'h07 |=>
      logical_unit_selector == $past(wr_data)) else $error("selector not written");
   chk_map_write: assert property (data_wr && glb_index == 8'h10 |=>
      memory_space_enable == $past(wr_data[0])) else $error("map enable not written");
   chk_base_top: assert property (data_wr && glb_index == 8'h13 |=>
      memory_base_upper[15:8] == $past(wr_data)) else $error("base top not written");
   chk_space_gate: assert property (
      (unit_in_memory & ~{NUM_UNITS{memory_space_enable}}) == '0)
      else $error("memory map without enable");
   chk_wake_sticky: assert property (
      (unit_irq_wake_status & $past(unit_irq_wake_status)) == $past(unit_irq_wake_status))
      else $error("wake status lost");
   chk_event_cause: assert property (power_event_request |-> $past(|unit_irq))
      else $error("power event without interrupt");
   chk_dma_none: assert property (data_rd && glb_index == 8'h74 &&
      logical_unit_selector < NUM_UNITS |=> rd_data == 8'h04) else $error("dma index wrong");
   cover property (power_event_request);
   cover property (glb_rd);
   cover property (|unit_in_memory);
endmodule
bind lucb_config_bank lucb_config_bank_monitor #(.NUM_UNITS(NUM_UNITS)) mon (.*);

// ===== testbench/lucb_host_model.sv
/*
 host side of the index/data port pair.
 assumes strobes are taken on the rising edge of clk.
*/
module lucb_host_model (
   input wire logic clk,
   output logic index_wr,
   output logic index_rd,
   output logic data_wr,
   output logic data_rd,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // idle values
   initial begin
      {index_wr, index_rd, data_wr, data_rd} = 4'h0;
      wr_data = 8'h00;
   end
   // whole value written directly, bus inverted once released
   task automatic put(input logic [7:0] idx, input logic [7:0] d);
      @(negedge clk);
      index_wr = 1'b1;
      wr_data = idx;
      @(negedge clk);
      index_wr = 1'b0;
      data_wr = 1'b1;
      wr_data = d;
      @(negedge clk);
      data_wr = 1'b0;
      wr_data = ~d;
   endtask
   task automatic get(input logic [7:0] idx, output logic [7:0] d);
      @(negedge clk);
      index_wr = 1'b1;
      wr_data = idx;
      @(negedge clk);
      index_wr = 1'b0;
      data_rd = 1'b1;
      wr_data = ~idx;
      @(negedge clk);
      data_rd = 1'b0;
      d = rd_data;
   endtask
   task automatic idx_get(output logic [7:0] d);
      @(negedge clk);
      index_rd = 1'b1;
      @(negedge clk);
      index_rd = 1'b0;
      d = rd_data;
   endtask
   // read-modify-write keeps the other bits
   task automatic rmw(input logic [7:0] idx, input logic [7:0] set);
      logic [7:0] v;
      get(idx, v);
      put(idx, v | set);
   endtask
endmodule

// ===== testbench/lucb_config_bank_tb_top.sv
/*
 self-checking bench for the configuration bank.
 assumes the host model and the bound checker.
*/
module lucb_config_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // signals and instances
   localparam int N = 9;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic index_wr, index_rd, data_wr, data_rd, glb_wr, glb_rd, memory_space_enable;
   logic power_event_request;
   logic [7:0] wr_data, rd_data, glb_index, logical_unit_selector, v;
   logic [7:0] glb_rd_data = 8'h00;
   logic [15:0] memory_base_upper;
   logic [N-1:0] unit_irq = '0;
   logic [N-1:0] unit_active, unit_in_memory, unit_irq_wake_status;
   logic [N*16-1:0] unit_io_base0, unit_io_base1;
   logic [N*4-1:0] unit_irq_line;
   logic [N*2-1:0] unit_irq_type;
   int errors = 0;
   int n_tests = 0;
   int glb_wr_cnt = 0;
   int glb_rd_cnt = 0;
`define CHK(a, b) n_tests++; \
   if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t got %h exp %h", $time, a, b); end
   lucb_config_bank #(.NUM_UNITS(N), .FIXED_TYPE(9'h010)) dut (.*);
   lucb_host_model host (.*);
   // clock
   always #5 clk = ~clk;
   // counts of global strobes taken on the rising edge
   always @(posedge clk) begin
      glb_wr_cnt <= glb_wr_cnt + int'(glb_wr);
      glb_rd_cnt <= glb_rd_cnt + int'(glb_rd);
   end
   // =========================================
   // scenarios
   task automatic t_reset();
      host.idx_get(v);
      `CHK(v, 8'h00);
      host.get(8'h07, v);
      `CHK(v, 8'h00);
      host.get(8'h30, v);
      `CHK(v, 8'h00);
      host.get(8'h70, v);
      `CHK(v, 8'h00);
      `CHK(unit_active, 9'h000);
      $display("t_reset done");
   endtask
   task automatic t_global();
      host.put(8'h07, 8'h03);
      `CHK(logical_unit_selector, 8'h03);
      host.put(8'h10, 8'h01);
      `CHK(memory_space_enable, 1'b1);
      host.put(8'h12, 8'ha5);
      host.put(8'h13, 8'h3c);
      `CHK(memory_base_upper, 16'h3ca5);
      host.get(8'h12, v);
      `CHK(v, 8'ha5);
      glb_rd_data = 8'h5a;
      host.put(8'h22, 8'h77);
      `CHK(glb_index, 8'h22);
      `CHK(glb_wr_cnt, 1);
      host.get(8'h27, v);
      `CHK(v, 8'h5a);
      `CHK(glb_rd_cnt, 1);
      $display("t_global done");
   endtask
   task automatic t_bank();
      for (int u = 2; u < 4; u++) begin
         host.put(8'h07, 8'(u));
         host.put(8'h30, 8'hff);
         host.put(8'h50, 8'hff);
         host.put(8'h71, 8'hff);
         host.put(8'h60, 8'(u));
         host.put(8'h61, 8'hc0);
         host.put(8'h63, 8'(u + 16));
         host.put(8'h70, 8'(8'he0 | u));
      end
      host.put(8'h07, 8'h02);
      host.get(8'h30, v);
      `CHK(v, 8'h01);
      host.get(8'h50, v);
      `CHK(v, 8'h01);
      host.get(8'h70, v);
      `CHK(v, 8'h02);
      host.get(8'h71, v);
      `CHK(v, 8'h03);
      `CHK(unit_io_base0[32+:16], 16'h02c0);
      `CHK(unit_io_base1[32+:16], 16'h0012);
      `CHK(unit_irq_line[8+:4], 4'h2);
      `CHK(unit_irq_type[4+:2], 2'b11);
      `CHK(unit_active, 9'h00c);
      `CHK(unit_in_memory, 9'h00c);
      host.put(8'h10, 8'h00);
      `CHK(unit_in_memory, 9'h000);
      $display("t_bank done");
   endtask
   task automatic t_refuse();
      host.get(8'h05, v);
      `CHK(v, 8'h00);
      host.get(8'h74, v);
      `CHK(v, 8'h04);
      host.get(8'h75, v);
      `CHK(v, 8'h04);
      host.put(8'h08, 8'hff);
      host.get(8'h08, v);
      `CHK(v, 8'h00);
      host.put(8'h07, 8'h04);
      host.put(8'h71, 8'h02);
      host.get(8'h71, v);
      `CHK(v, 8'h01);
      host.put(8'h07, 8'h0a);
      host.put(8'h30, 8'h01);
      host.get(8'h30, v);
      `CHK(v, 8'h00);
      `CHK(unit_active, 9'h00c);
      $display("t_refuse done");
   endtask
   task automatic t_wake();
      host.put(8'h07, 8'h01);
      host.put(8'h70, 8'h05);
      unit_irq[1] = 1'b1;
      repeat (3) @(negedge clk);
      `CHK(power_event_request, 1'b0);
      `CHK(unit_irq_wake_status, 9'h000);
      unit_irq[1] = 1'b0;
      host.rmw(8'h70, 8'h10);
      host.get(8'h70, v);
      `CHK(v, 8'h15);
      unit_irq[1] = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(power_event_request, 1'b1);
      unit_irq[1] = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(power_event_request, 1'b0);
      `CHK(unit_irq_wake_status, 9'h002);
      $display("t_wake done");
   endtask
   task automatic t_rst_mid();
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      `CHK(unit_active, 9'h000);
      `CHK(unit_irq_wake_status, 9'h000);
      host.put(8'h07, 8'h02);
      host.get(8'h50, v);
      `CHK(v, 8'h00);
      host.put(8'h07, 8'h01);
      host.get(8'h70, v);
      `CHK(v, 8'h00);
      $display("t_rst_mid done");
   endtask
   // =========================================
   // verdict, main sequence, watchdog
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_global();
      t_bank();
      t_refuse();
      t_wake();
      t_rst_mid();
      results();
   end
   initial begin
      #100000;
      errors++;
      results();
   end
endmodule
